// ### abk_pkg.sv
// package: register map, field positions and constants of the bank-four config
package abk_pkg;
	// register offsets
	localparam logic [7:0] ABK_ADDR_INSEL = 8'h3b;
	localparam logic [7:0] ABK_ADDR_PWR = 8'h3c;
	localparam logic [7:0] ABK_ADDR_CLKDLY = 8'h43;
	// reset values
	localparam logic [15:0] ABK_INSEL_RST = 16'h0000;
	localparam logic [15:0] ABK_PWR_RST = 16'h0000;
	localparam logic [15:0] ABK_CLKDLY_RST = 16'h0000;
	// input-select register fields
	localparam int ABK_PAIR_SEL_LSB = 8;
	localparam int ABK_PAT15_LSB = 5;
	localparam int ABK_PAT16_LSB = 2;
	localparam int ABK_PAT_W = 3;
	// bits that exist (all else reads as zero and is not stored)
	localparam logic [15:0] ABK_INSEL_MASK = 16'h0ffc;
	localparam logic [15:0] ABK_CLKDLY_MASK = 16'h001e;
	// power register fields
	localparam int ABK_DIG_OFF_LSB = 12;
	localparam int ABK_LANE_OFF_LSB = 8;
	localparam int ABK_ANA_OFF_LSB = 4;
	localparam int ABK_INV_LSB = 0;
	// clock-delay field
	localparam int ABK_DLY_LSB = 1;
	localparam int ABK_DLY_W = 4;
	localparam int ABK_DLY_STEP_PS = 110;
	// lane data width
	localparam int ABK_DATA_W = 14;
	// lanes handled: 13..16, index 0..3
	localparam int ABK_NLANE = 4;
	localparam logic [ABK_DATA_W-1:0] ABK_ZERO_DATA = 14'h0000;
endpackage : abk_pkg

// ### abk_regfile.sv
// file: three-word configuration store with registered read data
`timescale 1ns/1ns
module abk_regfile (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [15:0] rdata,
	output logic [15:0] insel_q,
	output logic [15:0] pwr_q,
	output logic [15:0] clkdly_q
);
	import abk_pkg::*;

	logic [15:0] insel_r;
	logic [15:0] pwr_r;
	logic [15:0] clkdly_r;
	logic [15:0] rdata_r;

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// all fields writable, zero after reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			insel_r <= ABK_INSEL_RST;
			pwr_r <= ABK_PWR_RST;
			clkdly_r <= ABK_CLKDLY_RST;
		end else if (ce && wr_en) begin
			case (addr)
				ABK_ADDR_INSEL: insel_r <= wdata & ABK_INSEL_MASK;
				ABK_ADDR_PWR: pwr_r <= wdata;
				ABK_ADDR_CLKDLY: clkdly_r <= wdata & ABK_CLKDLY_MASK;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	// read data one cycle after the strobe, zero for unmapped or idle, held while ce is low
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 16'h0000;
		end else if (ce) begin
			if (rd_en) begin
				case (addr)
					ABK_ADDR_INSEL: rdata_r <= insel_r;
					ABK_ADDR_PWR: rdata_r <= pwr_r;
					ABK_ADDR_CLKDLY: rdata_r <= clkdly_r;
					default: rdata_r <= 16'h0000;
				endcase
			end else begin
				rdata_r <= 16'h0000;
			end
		end
	end

	assign rdata = rdata_r;
	assign insel_q = insel_r;
	assign pwr_q = pwr_r;
	assign clkdly_q = clkdly_r;
endmodule : abk_regfile

// ### abk_bank.sv
// file: top of the converter 13-16 configuration and lane output slice
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns

module abk_bank (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic mode_16in,
	input wire logic per_lane_pattern_select,
	input wire logic [3:0] lane_pattern_active,
	input wire logic [abk_pkg::ABK_DATA_W-1:0] conv_data [4],
	input wire logic [abk_pkg::ABK_DATA_W-1:0] pattern_data [4],
	output logic [3:0] conv_pair_odd,
	output logic [5:0] conv_pair_num [4],
	output logic [2:0] lane15_pattern_code,
	output logic [2:0] lane16_pattern_code,
	output logic lane15_code_valid,
	output logic lane16_code_valid,
	output logic [3:0] conv_digital_off,
	output logic [3:0] conv_analog_off,
	output logic [3:0] lane_off,
	output logic [abk_pkg::ABK_DATA_W-1:0] lane_data [4],
	output logic signed [3:0] out_clock_delay_steps,
	output logic signed [10:0] out_clock_delay_ps
);
	import abk_pkg::*;

	logic [15:0] insel_q;
	logic [15:0] pwr_q;
	logic [15:0] clkdly_q;
	logic [ABK_DATA_W-1:0] lane_data_r [4];
	logic [5:0] pair_num_r [4];
	// named control fields, one per documented field
	logic conv13_pair_select;
	logic conv14_pair_select;
	logic conv15_pair_select;
	logic conv16_pair_select;
	logic conv13_digital_off;
	logic conv14_digital_off;
	logic conv15_digital_off;
	logic conv16_digital_off;
	logic lane13_off;
	logic lane14_off;
	logic lane15_off;
	logic lane16_off;
	logic conv13_analog_off;
	logic conv14_analog_off;
	logic conv15_analog_off;
	logic conv16_analog_off;
	logic lane13_data_invert;
	logic lane14_data_invert;
	logic lane15_data_invert;
	logic lane16_data_invert;
	// the same fields gathered per converter, index 0 = converter 13
	logic [3:0] pair_sel_v;
	logic [3:0] dig_off_v;
	logic [3:0] lane_off_v;
	logic [3:0] ana_off_v;
	logic [3:0] invert_v;

	// ----------------------------------------
	// register store
	// ----------------------------------------
	abk_regfile u_regs (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.addr(reg_addr),
		.wdata(reg_wdata),
		.wr_en(reg_wr),
		.rd_en(reg_rd),
		.rdata(reg_rdata),
		.insel_q(insel_q),
		.pwr_q(pwr_q),
		.clkdly_q(clkdly_q)
	);

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	// input-pair selects, converter 13 on bit 11
	assign conv13_pair_select = insel_q[ABK_PAIR_SEL_LSB + 3];
	assign conv14_pair_select = insel_q[ABK_PAIR_SEL_LSB + 2];
	assign conv15_pair_select = insel_q[ABK_PAIR_SEL_LSB + 1];
	assign conv16_pair_select = insel_q[ABK_PAIR_SEL_LSB];
	// digital power-down, converter 13 on bit 12
	assign conv13_digital_off = pwr_q[ABK_DIG_OFF_LSB];
	assign conv14_digital_off = pwr_q[ABK_DIG_OFF_LSB + 1];
	assign conv15_digital_off = pwr_q[ABK_DIG_OFF_LSB + 2];
	assign conv16_digital_off = pwr_q[ABK_DIG_OFF_LSB + 3];
	// lane power-down, lane 13 on bit 8
	assign lane13_off = pwr_q[ABK_LANE_OFF_LSB];
	assign lane14_off = pwr_q[ABK_LANE_OFF_LSB + 1];
	assign lane15_off = pwr_q[ABK_LANE_OFF_LSB + 2];
	assign lane16_off = pwr_q[ABK_LANE_OFF_LSB + 3];
	// analog power-down, converter 13 on bit 4
	assign conv13_analog_off = pwr_q[ABK_ANA_OFF_LSB];
	assign conv14_analog_off = pwr_q[ABK_ANA_OFF_LSB + 1];
	assign conv15_analog_off = pwr_q[ABK_ANA_OFF_LSB + 2];
	assign conv16_analog_off = pwr_q[ABK_ANA_OFF_LSB + 3];
	// data inversion, lane 13 on bit 0
	assign lane13_data_invert = pwr_q[ABK_INV_LSB];
	assign lane14_data_invert = pwr_q[ABK_INV_LSB + 1];
	assign lane15_data_invert = pwr_q[ABK_INV_LSB + 2];
	assign lane16_data_invert = pwr_q[ABK_INV_LSB + 3];
	// gather each field per converter for the generate loop below
	assign pair_sel_v = {conv16_pair_select, conv15_pair_select,
		conv14_pair_select, conv13_pair_select};
	assign dig_off_v = {conv16_digital_off, conv15_digital_off,
		conv14_digital_off, conv13_digital_off};
	assign lane_off_v = {lane16_off, lane15_off, lane14_off, lane13_off};
	assign ana_off_v = {conv16_analog_off, conv15_analog_off,
		conv14_analog_off, conv13_analog_off};
	assign invert_v = {lane16_data_invert, lane15_data_invert,
		lane14_data_invert, lane13_data_invert};

	// ----------------------------------------
	// per-converter controls (index 0 = converter 13)
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < ABK_NLANE; g++) begin : g_conv
			// select bit 11-g belongs to converter 13+g
			assign conv_pair_odd[g] = pair_sel_v[g];
			// pair number 25+2g or 26+2g, only meaningful in 16-input mode
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					pair_num_r[g] <= 6'h00;
				end else if (ce) begin
					if (mode_16in) begin
						pair_num_r[g] <= 6'(25 + 2 * g)
							+ {5'h00, pair_sel_v[g]};
					end else begin
						pair_num_r[g] <= 6'h00;
					end
				end
			end
			assign conv_pair_num[g] = pair_num_r[g];
			// bit order runs from converter 13 on bit 0 up to 16 on bit 3
			assign conv_digital_off[g] = dig_off_v[g];
			assign lane_off[g] = lane_off_v[g];
			assign conv_analog_off[g] = ana_off_v[g];
			// lane mux: pattern passes untouched, data may be inverted
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					lane_data_r[g] <= ABK_ZERO_DATA;
				end else if (ce) begin
					if (lane_off_v[g]) begin
						lane_data_r[g] <= ABK_ZERO_DATA;
					end else if (lane_pattern_active[g]) begin
						lane_data_r[g] <= pattern_data[g];
					end else if (invert_v[g]) begin
						lane_data_r[g] <= ~conv_data[g];
					end else begin
						lane_data_r[g] <= conv_data[g];
					end
				end
			end
			assign lane_data[g] = lane_data_r[g];
		end
	endgenerate

	// ----------------------------------------
	// per-lane test-pattern codes
	// ----------------------------------------
	// codes are offered always; valid only with per-lane selection on
	assign lane15_pattern_code = insel_q[ABK_PAT15_LSB +: ABK_PAT_W];
	assign lane16_pattern_code = insel_q[ABK_PAT16_LSB +: ABK_PAT_W];
	assign lane15_code_valid = per_lane_pattern_select;
	assign lane16_code_valid = per_lane_pattern_select;

	// ----------------------------------------
	// data clock delay
	// ----------------------------------------
	// signed step count and its value in picoseconds
	assign out_clock_delay_steps = signed'(clkdly_q[ABK_DLY_LSB +: ABK_DLY_W]);
	assign out_clock_delay_ps = 11'(out_clock_delay_steps
		* 11'(ABK_DLY_STEP_PS));
endmodule : abk_bank

// ### abk_bank_asserts.sv
// checker: bus and field-decode properties of the bank-four slice
`timescale 1ns/1ns
module abk_bank_asserts (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic [3:0] conv_pair_odd,
	input wire logic [2:0] lane15_pattern_code,
	input wire logic [2:0] lane16_pattern_code,
	input wire logic [3:0] conv_digital_off,
	input wire logic [3:0] conv_analog_off,
	input wire logic [3:0] lane_off,
	input wire logic signed [3:0] out_clock_delay_steps
);
	import abk_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// write data of the last cycle; select bits put in converter order
	logic [15:0] wd_q;
	wire [3:0] sel_rev = {wd_q[8], wd_q[9], wd_q[10], wd_q[11]};
	always_ff @(posedge mclk) wd_q <= reg_wdata;
	// a write taken at each offset
	sequence w_sel; ce && reg_wr && reg_addr == ABK_ADDR_INSEL; endsequence
	sequence w_pwr; ce && reg_wr && reg_addr == ABK_ADDR_PWR; endsequence
	sequence w_dly; ce && reg_wr && reg_addr == ABK_ADDR_CLKDLY; endsequence
	pair_sel_a: assert property (
		w_sel |=> conv_pair_odd == sel_rev) else $error("pair select");
	pat_code_a: assert property (
		w_sel |=> {lane15_pattern_code, lane16_pattern_code} == wd_q[7:2])
		else $error("pattern code");
	dig_off_a: assert property (
		w_pwr |=> conv_digital_off == wd_q[15:12]) else $error("digital off");
	lane_off_a: assert property (
		w_pwr |=> lane_off == wd_q[11:8]) else $error("lane off");
	ana_off_a: assert property (
		w_pwr |=> conv_analog_off == wd_q[7:4]) else $error("analog off");
	clk_delay_a: assert property (
		w_dly |=> out_clock_delay_steps == $signed(wd_q[4:1]))
		else $error("clock delay");
	rd_idle_a: assert property (
		ce && !reg_rd |=> reg_rdata == 16'h0000) else $error("idle read data");
	rd_power_a: assert property (
		ce && reg_rd && reg_addr == ABK_ADDR_PWR |=>
		reg_rdata[15:4] == {conv_digital_off, lane_off, conv_analog_off})
		else $error("power readback");
endmodule : abk_bank_asserts

// ### abk_rx_model.sv
// receiver model: latches the four lane words every clock
`timescale 1ns/1ns
module abk_rx_model (
	input wire logic mclk,
	input wire logic [13:0] lane_data [4],
	output logic [55:0] rx_word
);
	// capture lanes 13 to 16, lane 16 on top
	always_ff @(posedge mclk) begin
		rx_word <= {lane_data[3], lane_data[2], lane_data[1], lane_data[0]};
	end
endmodule : abk_rx_model

// ### abk_bank_bench.sv
// testbench: register access and lane output checks for the bank-four slice
`timescale 1ns/1ns
module abk_bank_bench;
	import abk_pkg::*;
	logic mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic mode_16in = 1'b0, per_lane_pattern_select = 1'b0;
	logic rv = 1'b0, go = 1'b0, dv = 1'b0;
	logic [1:0] lv = 2'b00;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, pw = 16'h0000, sv = 16'h0000;
	logic [3:0] lane_pattern_active = 4'h0;
	logic [13:0] conv_data [4] = '{default: 14'h0000};
	logic [13:0] pattern_data [4] = '{default: 14'h0000};
	logic [13:0] lane_data [4];
	logic [55:0] rx_word, lq [$];
	logic [15:0] rq [$];
	logic [5:0] pair_num [4];
	logic code_ok15, code_ok16;
	logic [10:0] dly_ps;
	logic [23:0] pq [$];
	logic [1:0] vq [$];
	logic [10:0] dq [$];
	logic [7:0] ad [4] = '{ABK_ADDR_INSEL, ABK_ADDR_PWR, ABK_ADDR_CLKDLY, 8'h40};
	logic [15:0] mk [4] = '{ABK_INSEL_MASK, 16'hffff, ABK_CLKDLY_MASK, 16'hffff};
	int n_errors = 0, cmp_count = 0;
	abk_bank u_abk_bank (
		.mclk(mclk),
		.rst_n(rst_n),
		.ce(ce),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.mode_16in(mode_16in),
		.per_lane_pattern_select(per_lane_pattern_select),
		.lane_pattern_active(lane_pattern_active),
		.conv_data(conv_data),
		.pattern_data(pattern_data),
		.conv_pair_odd(),
		.conv_pair_num(pair_num),
		.lane15_pattern_code(),
		.lane16_pattern_code(),
		.lane15_code_valid(code_ok15),
		.lane16_code_valid(code_ok16),
		.conv_digital_off(),
		.conv_analog_off(),
		.lane_off(),
		.lane_data(lane_data),
		.out_clock_delay_steps(),
		.out_clock_delay_ps(dly_ps)
	);
	abk_rx_model u_abk_rx_model (
		.mclk(mclk),
		.lane_data(lane_data),
		.rx_word(rx_word)
	);
	// free-running clock
	always #10 mclk = ~mclk;
	// compare one answer with its note
	task automatic chk(input logic [55:0] x, input logic [55:0] y);
		cmp_count++;
		if (x !== y) begin
			n_errors++;
			$display("[ERR] %0t exp %h got %h", $time, x, y);
		end
	endtask : chk
	// one register access over two cycles; a read notes its answer
	task automatic bus(input logic w, logic [7:0] a, logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		if (!w) rq.push_back(d);
		if (w && a == ABK_ADDR_CLKDLY)
			dq.push_back(11'($signed(d[4:1]) * ABK_DLY_STEP_PS));
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge mclk);
	endtask : bus
	// print the counts and the verdict
	task automatic wrap_up();
		// any notes never answered count as one mismatch
		if (rq.size() + lq.size() + pq.size() + vq.size() + dq.size() != 0)
			n_errors++;
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	// track answer cycles and compare each answer with the oldest note
	always @(posedge mclk) begin
		if (rv) chk(56'(rq.pop_front()), 56'(reg_rdata));
		if (lv[1]) chk(lq.pop_front(), rx_word);
		if (lv[0]) chk(56'(pq.pop_front()), 56'({pair_num[3], pair_num[2],
			pair_num[1], pair_num[0]}));
		if (go) chk(56'(vq.pop_front()), 56'({code_ok15, code_ok16}));
		if (dv) chk(56'(dq.pop_front()), 56'(dly_ps));
		rv <= reg_rd;
		lv <= {lv[0], go};
		dv <= ce && reg_wr && reg_addr == ABK_ADDR_CLKDLY;
	end
	// reset values, delay codes, random readback and lane traffic
	initial begin
		logic [15:0] d;
		logic [13:0] c, p;
		logic [3:0] a;
		logic [55:0] e;
		logic [23:0] q;
		void'($urandom(32'h4af7));
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 4; i++) bus(1'b0, ad[i], 16'h0000);
		for (int i = 0; i < 16; i++) bus(1'b1, ad[2], 16'(i << 1));
		repeat (6) begin
			for (int i = 0; i < 4; i++) begin
				d = 16'($urandom) & mk[i];
				bus(1'b1, ad[i], d);
				bus(1'b0, ad[i], i < 3 ? d : 16'h0000);
				if (i == 0) sv = d;
				if (i == 1) pw = d;
			end
			go <= 1'b1;
			repeat (8) begin
				a = 4'($urandom);
				lane_pattern_active <= a;
				mode_16in <= a[0];
				per_lane_pattern_select <= a[1];
				for (int g = 0; g < 4; g++) begin
					c = 14'($urandom);
					p = 14'($urandom);
					conv_data[g] <= c;
					pattern_data[g] <= p;
					e[14*g +: 14] = pw[8+g] ? 14'h0000 : a[g] ? p : pw[g] ? ~c : c;
					q[6*g +: 6] = 6'(a[0] ? 25 + 2 * g + sv[11 - g] : 0);
				end
				lq.push_back(e);
				pq.push_back(q);
				vq.push_back({a[1], a[1]});
				@(posedge mclk);
			end
			go <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		// clock enable low: a write must leave the power word untouched
		ce <= 1'b0;
		bus(1'b1, ABK_ADDR_PWR, ~pw);
		ce <= 1'b1;
		bus(1'b0, ABK_ADDR_PWR, pw);
		// reset in mid-run: every word reads zero again
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 4; i++) bus(1'b0, ad[i], 16'h0000);
		repeat (4) @(posedge mclk);
		wrap_up();
	end
endmodule : abk_bank_bench
bind abk_bank abk_bank_asserts u_abk_bank_asserts (
	.mclk(mclk),
	.rst_n(rst_n),
	.ce(ce),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.conv_pair_odd(conv_pair_odd),
	.lane15_pattern_code(lane15_pattern_code),
	.lane16_pattern_code(lane16_pattern_code),
	.conv_digital_off(conv_digital_off),
	.conv_analog_off(conv_analog_off),
	.lane_off(lane_off),
	.out_clock_delay_steps(out_clock_delay_steps)
);
